/* shared/mhf_pkg.sv */
// Package for the MAC hash filter and interpacket gap block.
// Assumes a 32-bit AHB-Lite register bus and a 250 MHz system clock.
package mhf_pkg;

  localparam int unsigned MHF_DATA_W = 32;
  localparam int unsigned MHF_ADDR_W = 8;
  localparam int unsigned MHF_GAP_W = 7;
  localparam int unsigned MHF_CNT_W = 8;
  localparam int unsigned MHF_HASH_W = 64;

  // Register base byte addresses; each but status has write, set, clear and invert words.
  localparam logic [7:0] MHF_HASH_LOW_OFS = 8'h00;
  localparam logic [7:0] MHF_HASH_HIGH_OFS = 8'h10;
  localparam logic [7:0] MHF_GAP_OFS = 8'h20;
  localparam logic [7:0] MHF_CTRL_OFS = 8'h30;
  localparam logic [7:0] MHF_STATUS_OFS = 8'h40;

  // Alias selected by byte address bits 3:2.
  localparam logic [1:0] MHF_OP_WRITE = 2'h0;
  localparam logic [1:0] MHF_OP_SET = 2'h1;
  localparam logic [1:0] MHF_OP_CLR = 2'h2;
  localparam logic [1:0] MHF_OP_INV = 2'h3;

  // Control register fields.
  localparam int unsigned MHF_CTRL_FULL_DUPLEX_BIT = 0;
  localparam int unsigned MHF_CTRL_RECEIVER_ON_BIT = 1;
  localparam int unsigned MHF_CTRL_HASH_FILTER_ON_BIT = 2;
  localparam int unsigned MHF_CTRL_W = 3;

  // Status register fields.
  localparam int unsigned MHF_STAT_GAP_BUSY_BIT = 0;
  localparam int unsigned MHF_STAT_HASH_LOCKED_BIT = 1;

  // Reset values.
  localparam logic [31:0] MHF_HASH_RESET = 32'h0000_0000;
  localparam logic [6:0] MHF_GAP_RESET = 7'h12;
  localparam logic [2:0] MHF_CTRL_RESET = 3'h0;

  // Duplex-dependent additions to the programmed gap, in nibble times.
  localparam logic [7:0] MHF_FULL_DUPLEX_ADD = 8'h03;
  localparam logic [7:0] MHF_HALF_DUPLEX_ADD = 8'h06;

  // AHB encodings.
  localparam logic [2:0] MHF_HSIZE_HALF = 3'h1;
  localparam logic [2:0] MHF_HSIZE_WORD = 3'h2;

endpackage

/* src/mhf_gap_timer.sv */
// Back-to-back gap timer of the transmit path.
// Assumes frame end and nibble tick pulses come from logic on the same clock.
`timescale 1ns/1ns
module mhf_gap_timer
  import mhf_pkg::*;
#(
  parameter int unsigned GAP_W = MHF_GAP_W,
  parameter int unsigned CNT_W = MHF_CNT_W
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [GAP_W-1:0] gap_field_i,
  input wire logic full_duplex_i,
  input wire logic frame_end_i,
  input wire logic nibble_tick_i,
  output logic busy_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic [CNT_W-1:0] target;
  logic [CNT_W-1:0] cnt_inc;

  assign target = CNT_W'(gap_field_i) + CNT_W'(full_duplex_i ? MHF_FULL_DUPLEX_ADD : MHF_HALF_DUPLEX_ADD);
  assign cnt_inc = cnt_q + CNT_W'(1);

  // hold off until gap elapsed.
  // A frame end restarts the count even while one is running.
  assign busy_d = frame_end_i ? 1'b1 : (busy_q && nibble_tick_i && cnt_inc >= target) ? 1'b0 : busy_q;
  assign cnt_d = frame_end_i ? '0 : (busy_q && nibble_tick_i) ? cnt_inc : cnt_q;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy_o = busy_q;

endmodule

/* src/mhf_top.sv */
// Hash table and interpacket gap registers of an Ethernet MAC, AHB-Lite slave.
// Assumes a zero-wait AHB-Lite master and transmit pulses on the same clock.
// Behaviour
// - 64-bit hash table in two words
// - hash table feeds receive filter only
// - seven-bit gap field in nibble times
// - full duplex gap is field plus three
// - half duplex gap is field plus six
// - halfword and word accesses, bytes ignored
// - gap register bits 31-7 read zero
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module mhf_top
  import mhf_pkg::*;
#(
  parameter int unsigned GAP_W = MHF_GAP_W
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic tx_frame_end_i,
  input wire logic nibble_tick_i,
  output logic tx_start_ok_o,
  output logic [MHF_HASH_W-1:0] hash_bits_o,
  output logic full_duplex_o
);

  // Address phase capture.
  logic wr_pend_q;
  logic wr_pend_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;

  // Register state.
  logic [31:0] hash_low_q;
  logic [31:0] hash_low_d;
  logic [31:0] hash_high_q;
  logic [31:0] hash_high_d;
  logic [GAP_W-1:0] gap_q;
  logic [GAP_W-1:0] gap_d;
  logic [MHF_CTRL_W-1:0] ctrl_q;
  logic [MHF_CTRL_W-1:0] ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Decoding.
  wire addr_take = hsel_i && htrans_i[1] && hready_i;
  wire [7:0] a_addr = haddr_i[7:0];
  wire [31:0] a_mask;
  wire a_legal;
  wire [1:0] wr_op = addr_q[3:2];
  wire [7:0] wr_base = {addr_q[7:4], 4'h0};
  wire [7:0] rd_base = {a_addr[7:4], 4'h0};
  wire hit_low = wr_pend_q && wr_base == MHF_HASH_LOW_OFS;
  wire hit_high = wr_pend_q && wr_base == MHF_HASH_HIGH_OFS;
  wire hit_gap = wr_pend_q && wr_base == MHF_GAP_OFS;
  wire hit_ctrl = wr_pend_q && wr_base == MHF_CTRL_OFS;
  wire hash_locked;
  wire gap_busy;
  wire [31:0] status_word;
  wire [31:0] hash_low_new;
  wire [31:0] hash_high_new;
  wire [31:0] gap_new;
  wire [31:0] ctrl_new;

  // Applies one write, set, clear or invert alias under a lane mask.
  function automatic logic [31:0] mhf_apply(input logic [31:0] old, input logic [31:0] wdata,
                                            input logic [31:0] mask, input logic [1:0] op);
    logic [31:0] res;
    res = old;
    unique case (op)
      MHF_OP_WRITE: res = (old & ~mask) | (wdata & mask);
      MHF_OP_SET: res = old | (wdata & mask);
      MHF_OP_CLR: res = old & ~(wdata & mask);
      MHF_OP_INV: res = old ^ (wdata & mask);
    endcase
    return res;
  endfunction

  // lane mask, bytes ignored.
  // A byte access yields an empty mask, so it stores nothing and reads zero.
  assign a_mask = (hsize_i == MHF_HSIZE_WORD) ? 32'hffff_ffff :
                  (hsize_i == MHF_HSIZE_HALF) ? (haddr_i[1] ? 32'hffff_0000 : 32'h0000_ffff) :
                  32'h0000_0000;
  assign a_legal = a_mask != 32'h0000_0000;

  assign wr_pend_d = addr_take && hwrite_i && a_legal;
  assign addr_d = addr_take ? a_addr : addr_q;
  assign mask_d = addr_take ? a_mask : mask_q;

  // table lock from controller bits.
  // Hash table writes while the receive filter is live are dropped, so a frame never sees a half-written table.
  assign hash_locked = ctrl_q[MHF_CTRL_RECEIVER_ON_BIT] && ctrl_q[MHF_CTRL_HASH_FILTER_ON_BIT];

  assign hash_low_new = mhf_apply(hash_low_q, hwdata_i, mask_q, wr_op);
  assign hash_high_new = mhf_apply(hash_high_q, hwdata_i, mask_q, wr_op);
  assign hash_low_d = (hit_low && !hash_locked) ? hash_low_new : hash_low_q;
  assign hash_high_d = (hit_high && !hash_locked) ? hash_high_new : hash_high_q;

  assign gap_new = mhf_apply({{(32 - GAP_W){1'b0}}, gap_q}, hwdata_i, mask_q, wr_op);
  assign gap_d = hit_gap ? gap_new[GAP_W-1:0] : gap_q;

  assign ctrl_new = mhf_apply({{(32 - MHF_CTRL_W){1'b0}}, ctrl_q}, hwdata_i, mask_q, wr_op);
  assign ctrl_d = hit_ctrl ? ctrl_new[MHF_CTRL_W-1:0] : ctrl_q;

  assign status_word = {30'h0000_0000, hash_locked, gap_busy};

  // Read data uses next-state values so a read right after a write sees it.
  // gap upper bits zero.
  assign rdata_d = !(addr_take && !hwrite_i && a_legal) ? 32'h0000_0000 :
                   (rd_base == MHF_HASH_LOW_OFS) ? hash_low_d :
                   (rd_base == MHF_HASH_HIGH_OFS) ? hash_high_d :
                   (rd_base == MHF_GAP_OFS) ? {{(32 - GAP_W){1'b0}}, gap_d} :
                   (rd_base == MHF_CTRL_OFS) ? {{(32 - MHF_CTRL_W){1'b0}}, ctrl_d} :
                   (rd_base == MHF_STATUS_OFS) ? status_word :
                   32'h0000_0000;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      mask_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_pend_d;
      addr_q <= addr_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hash_low_q <= MHF_HASH_RESET;
      hash_high_q <= MHF_HASH_RESET;
      gap_q <= GAP_W'(MHF_GAP_RESET);
      ctrl_q <= MHF_CTRL_RESET;
    end else begin
      hash_low_q <= hash_low_d;
      hash_high_q <= hash_high_d;
      gap_q <= gap_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Halfword data is placed on its lane by the master, so the read word is returned whole.
  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  assign hash_bits_o = {hash_high_q, hash_low_q};
  assign full_duplex_o = ctrl_q[MHF_CTRL_FULL_DUPLEX_BIT];

  mhf_gap_timer #(
    .GAP_W(GAP_W),
    .CNT_W(MHF_CNT_W)
  ) u_gap_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .gap_field_i(gap_q),
    .full_duplex_i(ctrl_q[MHF_CTRL_FULL_DUPLEX_BIT]),
    .frame_end_i(tx_frame_end_i),
    .nibble_tick_i(nibble_tick_i),
    .busy_o(gap_busy)
  );

  assign tx_start_ok_o = !gap_busy;

endmodule

/* sim/mhf_checker_properties.sv */
// Checker for the hash table and gap register block.
// Assumes it is bound to mhf_top and sees only its ports.
`timescale 1ns/1ns
module mhf_checker
  import mhf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic tx_frame_end_i,
  input wire logic nibble_tick_i,
  input wire logic tx_start_ok_o,
  input wire logic [MHF_HASH_W-1:0] hash_bits_o,
  input wire logic full_duplex_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire take = hsel_i & htrans_i[1] & hready_i;
  wire wr = take & hwrite_i;
  wire rd = take & !hwrite_i;
  a_bus_ready: assert property (hreadyout_o && !hresp_o)
    else $error("bus stalled or errored");
  a_idle_rdata: assert property (!rd |=> hrdata_o == 32'h0)
    else $error("read data without a read");
  a_gap_top_zero: assert property (rd && haddr_i[7:4] == 4'h2 |=> hrdata_o[31:7] == 25'h0)
    else $error("gap upper bits not zero");
  a_regs_hold: assert property (!$past(wr, 2) |-> $stable({hash_bits_o, full_duplex_o}))
    else $error("register changed without write");
  a_byte_ignored: assert property (wr && hsize_i == 3'h0 |=> ##1 $stable(hash_bits_o))
    else $error("byte write took effect");
  a_gap_start: assert property (tx_frame_end_i |=> !tx_start_ok_o [*3])
    else $error("gap shorter than minimum");
  a_ok_after_tick: assert property ($rose(tx_start_ok_o) |-> $past(nibble_tick_i))
    else $error("start allowed without nibble");
  a_ok_idle_hold: assert property (tx_start_ok_o && !tx_frame_end_i |=> tx_start_ok_o)
    else $error("start permission dropped");
  c_write: cover property (wr);
  c_gap_done: cover property ($rose(tx_start_ok_o));
  c_byte: cover property (wr && hsize_i == 3'h0);
endmodule
bind mhf_top mhf_checker i_mhf_checker (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .tx_frame_end_i(tx_frame_end_i),
  .nibble_tick_i(nibble_tick_i), .tx_start_ok_o(tx_start_ok_o), .hash_bits_o(hash_bits_o),
  .full_duplex_o(full_duplex_o));

/* sim/mhf_phy_model.sv */
// Media-side model: nibble ticks and transmit frame ends.
// Assumes end_frame is called just after a rising edge.
`timescale 1ns/1ns
module mhf_phy_model (
  input wire logic sys_clk_i,
  input wire logic slow_i,
  output logic nibble_tick_o,
  output logic tx_frame_end_o
);
  int ph = 0;
  initial nibble_tick_o = 1'b0;
  initial tx_frame_end_o = 1'b0;
  // Slow mode spaces nibbles three clocks apart, as a slower link would.
  always @(posedge sys_clk_i) begin
    ph <= (ph + 1) % 3;
    nibble_tick_o <= !slow_i || ph == 0;
  end
  task automatic end_frame();
    @(posedge sys_clk_i);
    tx_frame_end_o <= 1'b1;
    @(posedge sys_clk_i);
    tx_frame_end_o <= 1'b0;
  endtask
endmodule

/* sim/mac_hash_filter_and_ipg_tb.sv */
// Self-checking bench for the hash table and gap register block.
// Assumes the checker binds itself and the media model drives the transmit pulses.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module mac_hash_filter_and_ipg_tb
  import mhf_pkg::*;
;
  logic clk = 0, rst = 1, hsel = 0, hwr = 0, slow = 0, tick, fend, ok, fdx, rdy, resp;
  logic [1:0] htr = 0;
  logic [2:0] hsz = 0;
  logic [31:0] ha = 0, hwd = 0, hrd;
  logic [63:0] hb;
  logic [31:0] m [logic [7:0]];
  logic [8:0] gt [4] = '{9'h115, 9'h092, 9'h180, 9'h07f};
  int fails = 0, checks_done = 0, dummy;
  always #2 clk = ~clk;
  mhf_top i_mhf_top (.sys_clk_i(clk), .reset_i(rst), .hsel_i(hsel), .haddr_i(ha), .htrans_i(htr),
    .hwrite_i(hwr), .hsize_i(hsz), .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy),
    .hresp_o(resp), .tx_frame_end_i(fend), .nibble_tick_i(tick), .tx_start_ok_o(ok), .hash_bits_o(hb),
    .full_duplex_o(fdx));
  mhf_phy_model i_mhf_phy_model (.sys_clk_i(clk), .slow_i(slow), .nibble_tick_o(tick), .tx_frame_end_o(fend));
  task automatic acc(logic [7:0] a, logic w, logic [2:0] s, logic [31:0] d);
    logic [7:0] b;
    logic [31:0] k, o;
    b = a & 8'hf0;
    k = s == MHF_HSIZE_WORD ? '1 : s != MHF_HSIZE_HALF ? 32'h0 : a[1] ? 32'hffff0000 : 32'h0000ffff;
    hsel <= 1; htr <= 2'h2; ha <= {24'h0, a}; hwr <= w; hsz <= s;
    do @(posedge clk); while (!rdy);
    hsel <= 0; htr <= 0; hwd <= d;
    do @(posedge clk); while (!rdy);
    o = m.exists(b) ? m[b] : b == MHF_STATUS_OFS ? {30'h0, m[8'h30][2:1] == 2'h3, 1'b0} : 32'h0;
    if (!w) `CHK("read", o, hrd)
    else if (m.exists(b) && !(b < 8'h20 && m[8'h30][2:1] == 2'h3)) begin
      d &= k;
      m[b] = a[3:2] == 0 ? o & ~k | d : a[3:2] == 1 ? o | d : a[3:2] == 2 ? o & ~d : o ^ d;
      m[b] &= b == 8'h20 ? 32'h7f : b == 8'h30 ? 32'h7 : '1;
    end
    @(posedge clk);
    `CHK("regs", {m[8'h10], m[8'h00], m[8'h30][0]}, {hb, fdx})
  endtask
  task automatic gap_run(logic f, logic sl, logic [6:0] g);
    int n;
    logic t;
    n = 0;
    slow <= sl;
    acc(8'h30, 1, MHF_HSIZE_WORD, {31'h0, f});
    acc(8'h20, 1, MHF_HSIZE_WORD, {25'h0, g});
    i_mhf_phy_model.end_frame();
    #1;
    repeat (1000) begin
      t = tick;
      @(posedge clk);
      #1;
      n += t;
      if (ok === 1'b1) break;
    end
    `CHK("gap_end", 1'b1, ok)
    `CHK("gap", g + (f ? 3 : 6), n)
    @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    logic [2:0] s;
    dummy = $urandom(32'h4053658d);
    m = '{8'h00: 32'h0, 8'h10: 32'h0, 8'h20: 32'h12, 8'h30: 32'h0};
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    `CHK("ready", 1'b1, ok)
    for (int i = 0; i < 6; i++) acc(8'(16 * i), 0, MHF_HSIZE_WORD, 32'h0);
    for (int l = 0; l < 2; l++) begin
      acc(8'h30, 1, MHF_HSIZE_WORD, l ? 32'h6 : 32'h2);
      acc(MHF_STATUS_OFS, 0, MHF_HSIZE_WORD, 32'h0);
      for (int i = 0; i < 24; i++) begin
        s = 3'(2 - i / 8);
        acc(8'(16 * (i % 3) + 4 * (i % 4) + (s == 1 ? 2 * ($urandom % 2) : 0)), 1, s, $urandom);
        acc(8'(16 * (i % 3)), 0, MHF_HSIZE_WORD, 32'h0);
      end
    end
    foreach (gt[j]) gap_run(gt[j][8], gt[j][7], gt[j][6:0]);
    print_verdict();
  end
endmodule
